// File: core/crc_unit.sv
`timescale 1ns/1ns
`include "sw_link_consts.svh"
module crc_unit
   import sw_link_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   crc_if.unit       crc
);
   logic [7:0]  crc8_ff;
   logic [15:0] crc16_ff;
   logic        fb8;
   logic        fb16;

   assign fb8      = crc8_ff[0] ^ crc.bit_in;
   assign fb16     = crc16_ff[0] ^ crc.bit_in;
   assign crc.crc8  = crc8_ff;
   assign crc.crc16 = crc16_ff;

   // Reflected shift register: LSB-first bits
   always_ff @(posedge ref_clk) begin
      if (!rst_n || crc.clear) begin
         crc8_ff <= `CRC8_RESET;
      end else if (crc.shift) begin
         crc8_ff <= (crc8_ff >> 1) ^ (fb8 ? `CRC8_POLY_REFL : 8'h00);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || crc.clear) begin
         crc16_ff <= `CRC16_RESET;
      end else if (crc.shift) begin
         crc16_ff <= (crc16_ff >> 1) ^ (fb16 ? `CRC16_POLY_REFL : 16'h0000);
      end
   end

   a_crc_clear_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      crc.clear |=> (crc16_ff == 16'h0000)) else $error("crc16 not cleared");
   a_crc_hold_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !crc.clear && !crc.shift |=> $stable(crc16_ff)) else $error("crc16 moved without shift");
endmodule

// File: core/sw_link_slave.sv
`timescale 1ns/1ns
`include "sw_link_consts.svh"
module sw_link_slave
   import sw_link_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        line_in,
   output logic             line_out,
   output logic             line_oe,
   input  wire logic        od_set,
   input  wire logic        tx_req,
   input  wire logic        tx_bit,
   input  wire logic        crc_clear,
   input  wire logic        crc_feed,
   input  wire logic [4:0]  write_end_ofs,
   output logic             bit_valid_ff,
   output logic             bit_data_ff,
   output logic             bus_reset_ff,
   output logic             overdrive_flag_ff,
   output logic             speed_undef_ff,
   output logic             ready_ff,
   output logic [7:0]       crc8_out_ff,
   output logic [15:0]      crc16_tx_ff,
   output logic             crc16_send_ff
);
   logic [2:0]        sync_ff;
   logic              line_ff;
   logic              fell;
   logic              rose;
   logic [`CNT_W-1:0] low_cnt_ff;
   logic [`CNT_W-1:0] tmr_ff;
   link_state_t       state_ff;
   logic              slot_is_read_ff;
   logic              slot_bit_ff;
   logic              sampled_ff;
   logic              drive_ff;
   logic [`CNT_W-1:0] t_pdh;
   logic [`CNT_W-1:0] t_pdl;
   logic [`CNT_W-1:0] t_sample;
   logic [`CNT_W-1:0] t_hold0;
   logic [`CNT_W-1:0] t_rdet;
   logic              od_now;
   logic              pres_go_ff;
   logic [`CNT_W-1:0] pres_cnt_ff;

   crc_if crc ();

   crc_unit u_crc (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .crc     (crc.unit)
   );

   assign crc.clear  = crc_clear;
   assign crc.shift  = bit_valid_ff && crc_feed;
   assign crc.bit_in = bit_data_ff;

   // Three-stage sync; a change is taken when stages two and three agree.
   // Hysteresis is emulated: a filtered level only flips on agreement.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sync_ff <= 3'h7;
      end else begin
         sync_ff <= {sync_ff[1:0], line_in};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         line_ff <= 1'b1;
      end else if (sync_ff[1] == sync_ff[2]) begin
         line_ff <= sync_ff[2];
      end
   end

   assign fell = line_ff && (sync_ff[1] == sync_ff[2]) && !sync_ff[2];
   assign rose = !line_ff && (sync_ff[1] == sync_ff[2]) && sync_ff[2];

   // Fast timing set whenever overdrive is on
   assign od_now   = overdrive_flag_ff;
   assign t_pdh    = od_now ? `CNT_W'(`PDH_OD_CYC)    : `CNT_W'(`PDH_STD_CYC);
   assign t_pdl    = od_now ? `CNT_W'(`PDL_OD_CYC)    : `CNT_W'(`PDL_STD_CYC);
   assign t_sample = od_now ? `CNT_W'(`SAMPLE_OD_CYC) : `CNT_W'(`SAMPLE_STD_CYC);
   assign t_hold0  = od_now ? `CNT_W'(`HOLD0_OD_CYC)  : `CNT_W'(`HOLD0_STD_CYC);
   assign t_rdet   = od_now ? `CNT_W'(`RST_DETECT_OD_CYC) : `CNT_W'(`RST_DETECT_STD_CYC);

   // Low-time counter, saturating; measures reset length
   always_ff @(posedge ref_clk) begin
      if (!rst_n || line_ff) begin
         low_cnt_ff <= '0;
      end else if (low_cnt_ff != {`CNT_W{1'b1}}) begin
         low_cnt_ff <= low_cnt_ff + `CNT_W'(1);
      end
   end

   // Slot timer restarts on every master falling edge
   always_ff @(posedge ref_clk) begin
      if (!rst_n || fell) begin
         tmr_ff <= '0;
      end else if (tmr_ff != {`CNT_W{1'b1}}) begin
         tmr_ff <= tmr_ff + `CNT_W'(1);
      end
   end

   // Link sequencer
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff <= LINK_IDLE;
      end else begin
         unique case (state_ff)
            LINK_IDLE: begin
               if (fell) begin
                  state_ff <= LINK_LOW;
               end
            end
            LINK_LOW: begin
               if (rose) begin
                  state_ff <= (low_cnt_ff >= t_rdet) ? LINK_PDH : LINK_REC;
               end
            end
            // Presence is timed from the rise, not from the reset fall
            LINK_PDH: begin
               if (pres_cnt_ff >= t_pdh) begin
                  state_ff <= LINK_PDL;
               end
            end
            LINK_PDL: begin
               if (pres_cnt_ff >= t_pdh + t_pdl) begin
                  state_ff <= LINK_REC;
               end
            end
            LINK_REC: begin
               if (fell) begin
                  state_ff <= LINK_LOW;
               end else if (line_ff) begin
                  state_ff <= LINK_IDLE;
               end
            end
         endcase
      end
   end

   // Overdrive flag
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         overdrive_flag_ff <= 1'b0;
         speed_undef_ff    <= 1'b0;
      end else if (state_ff == LINK_LOW && rose && low_cnt_ff >= t_rdet) begin
         if (low_cnt_ff >= `CNT_W'(`RST_STD_MIN_CYC)) begin
            overdrive_flag_ff <= 1'b0;
            speed_undef_ff    <= 1'b0;
         end else if (overdrive_flag_ff && low_cnt_ff > `CNT_W'(`RST_OD_MAX_CYC)) begin
            speed_undef_ff    <= 1'b1; // kept in overdrive, flagged as undefined
         end else begin
            speed_undef_ff    <= 1'b0;
         end
      end else if (od_set) begin
         overdrive_flag_ff <= 1'b1;
      end
   end

   // Presence timer restarts on every rise out of LINK_LOW, reset or slot
   always_ff @(posedge ref_clk) begin
      if (!rst_n || (state_ff == LINK_LOW && rose)) begin
         pres_cnt_ff <= '0;
      end else if (pres_cnt_ff != {`CNT_W{1'b1}}) begin
         pres_cnt_ff <= pres_cnt_ff + `CNT_W'(1);
      end
   end
   assign pres_go_ff = (state_ff == LINK_PDL);

   // Bus reset pulse toward command logic
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bus_reset_ff <= 1'b0;
      end else begin
         bus_reset_ff <= (state_ff == LINK_LOW) && rose && (low_cnt_ff >= t_rdet);
      end
   end

   // Ready in recovery and idle, cleared while presence is timed or driven
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ready_ff <= 1'b0;
      end else if (state_ff == LINK_PDH || state_ff == LINK_PDL) begin
         ready_ff <= 1'b0;
      end else if (state_ff == LINK_REC || state_ff == LINK_IDLE) begin
         ready_ff <= 1'b1;
      end
   end

   // Slot kind latched at falling edge: read when command logic offers a bit
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         slot_is_read_ff <= 1'b0;
         slot_bit_ff     <= 1'b1;
      end else if (fell && state_ff != LINK_PDH && state_ff != LINK_PDL) begin
         slot_is_read_ff <= tx_req;
         slot_bit_ff     <= tx_bit;
      end
   end

   // One sample per slot at the timer instant
   always_ff @(posedge ref_clk) begin
      if (!rst_n || fell) begin
         sampled_ff   <= 1'b0;
         bit_valid_ff <= 1'b0;
         bit_data_ff  <= 1'b0;
      end else if (state_ff != LINK_PDH && state_ff != LINK_PDL && !sampled_ff && tmr_ff == t_sample) begin
         // A write-one has already risen here, so the slot may sit in recovery
         sampled_ff   <= 1'b1;
         bit_valid_ff <= 1'b1;
         bit_data_ff  <= slot_is_read_ff ? slot_bit_ff : line_ff;
      end else begin
         bit_valid_ff <= 1'b0;
      end
   end

   // Driver: presence low, or read-zero hold until timer ends
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         drive_ff <= 1'b0;
      end else if (pres_go_ff) begin
         drive_ff <= 1'b1;
      end else if (!line_ff && slot_is_read_ff && !slot_bit_ff && state_ff == LINK_LOW
                   && tmr_ff < t_hold0 && low_cnt_ff < t_rdet) begin
         drive_ff <= 1'b1;
      end else begin
         drive_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         line_out <= 1'b1;
         line_oe  <= 1'b0;
      end else begin
         line_out <= 1'b0;
         line_oe  <= drive_ff;
      end
   end

   // CRC outputs: 8-bit sent true, 16-bit sent inverted
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         crc8_out_ff   <= 8'h00;
         crc16_tx_ff   <= 16'hffff;
         crc16_send_ff <= 1'b0;
      end else begin
         crc8_out_ff   <= crc.crc8;
         crc16_tx_ff   <= ~crc.crc16;
         crc16_send_ff <= (write_end_ofs == `SCRATCH_END_OFS);
      end
   end

   a_od_long_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_ff == LINK_LOW && rose && low_cnt_ff >= `CNT_W'(`RST_STD_MIN_CYC)
      |=> !overdrive_flag_ff) else $error("long reset kept overdrive");
   a_od_short_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
      overdrive_flag_ff && state_ff == LINK_LOW && rose && low_cnt_ff <= `CNT_W'(`RST_OD_MAX_CYC)
      |=> overdrive_flag_ff) else $error("short reset left overdrive");
   a_od_set_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
      od_set && !(state_ff == LINK_LOW && rose) |=> overdrive_flag_ff) else $error("od not set");
   a_drive_no_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(line_oe) && state_ff != LINK_PDL && state_ff != LINK_REC |-> !line_ff)
      else $error("slave made a falling edge");
   a_pres_after_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_ff == LINK_PDH ##1 state_ff == LINK_PDL |-> ##2 line_oe) else $error("no presence");
   a_read_one_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      slot_is_read_ff && slot_bit_ff && state_ff == LINK_LOW |-> ##1 !drive_ff) else $error("read one drove");
   a_crc_inverted: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> crc16_tx_ff == ~$past(crc.crc16)) else $error("crc16 not inverted");
   a_crc_send_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
      write_end_ofs != `SCRATCH_END_OFS |=> !crc16_send_ff) else $error("crc sent early");
   a_one_bit_slot: assert property (@(posedge ref_clk) disable iff (!rst_n)
      bit_valid_ff |=> !bit_valid_ff) else $error("two bits in one slot");
   a_speed_fast: assert property (@(posedge ref_clk) disable iff (!rst_n)
      overdrive_flag_ff |-> t_sample == `CNT_W'(`SAMPLE_OD_CYC)) else $error("slow timing in od");
   a_ready_in_pres: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_ff == LINK_PDL |=> !ready_ff) else $error("ready during presence");
   a_ready_at_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_ff == LINK_IDLE |=> ready_ff) else $error("not ready at idle");
   a_bus_reset_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
      bus_reset_ff |=> !bus_reset_ff) else $error("reset pulse too long");
   a_undef_mid: assert property (@(posedge ref_clk) disable iff (!rst_n)
      overdrive_flag_ff && state_ff == LINK_LOW && rose && low_cnt_ff > `CNT_W'(`RST_OD_MAX_CYC)
      && low_cnt_ff < `CNT_W'(`RST_STD_MIN_CYC) |=> speed_undef_ff) else $error("undef not flagged");
   a_read_zero_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      slot_is_read_ff && !slot_bit_ff && state_ff == LINK_LOW && !line_ff && tmr_ff < t_hold0
      && low_cnt_ff < t_rdet |=> drive_ff) else $error("read zero not held");
   a_sample_instant: assert property (@(posedge ref_clk) disable iff (!rst_n)
      bit_valid_ff |-> $past(tmr_ff) == $past(t_sample)) else $error("sample off timer");
   a_glitch_filter: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sync_ff[1] != sync_ff[2] |=> line_ff == $past(line_ff)) else $error("unfiltered change");
   a_write_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
      bit_valid_ff && !slot_is_read_ff |-> bit_data_ff == $past(line_ff)) else $error("write bit wrong");
   a_od_only_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(overdrive_flag_ff) |-> $past(od_set)) else $error("od set without command");
   a_pdh_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_ff == LINK_PDH |-> !drive_ff) else $error("drove before presence");
endmodule

// File: shared/crc_if.sv
`timescale 1ns/1ns
interface crc_if;
   logic        clear;
   logic        shift;
   logic        bit_in;
   logic [7:0]  crc8;
   logic [15:0] crc16;
   modport engine (output clear, output shift, output bit_in, input crc8, input crc16);
   modport unit   (input clear, input shift, input bit_in, output crc8, output crc16);
endinterface

// File: shared/sw_link_consts.svh
`ifndef SW_LINK_CONSTS_SVH
`define SW_LINK_CONSTS_SVH
// Timing figures in ns, counts derived at 50 ns per cycle
`define CLK_PERIOD_NS        50
`define RST_STD_MIN_NS       480000
`define RST_OD_MAX_NS        80000
`define RST_STD_MIN_CYC      ((`RST_STD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_OD_MAX_CYC       (`RST_OD_MAX_NS / `CLK_PERIOD_NS)
`define RST_DETECT_STD_NS    120000
`define RST_DETECT_OD_NS     16000
`define RST_DETECT_STD_CYC   ((`RST_DETECT_STD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_DETECT_OD_CYC    ((`RST_DETECT_OD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PDH_STD_NS           30000
`define PDH_OD_NS            3000
`define PDL_STD_NS           120000
`define PDL_OD_NS            12000
`define SAMPLE_STD_NS        30000
`define SAMPLE_OD_NS         4000
`define HOLD0_STD_NS         45000
`define HOLD0_OD_NS          6000
`define PDH_STD_CYC          (`PDH_STD_NS / `CLK_PERIOD_NS)
`define PDH_OD_CYC           (`PDH_OD_NS / `CLK_PERIOD_NS)
`define PDL_STD_CYC          (`PDL_STD_NS / `CLK_PERIOD_NS)
`define PDL_OD_CYC           (`PDL_OD_NS / `CLK_PERIOD_NS)
`define SAMPLE_STD_CYC       (`SAMPLE_STD_NS / `CLK_PERIOD_NS)
`define SAMPLE_OD_CYC        (`SAMPLE_OD_NS / `CLK_PERIOD_NS)
`define HOLD0_STD_CYC        (`HOLD0_STD_NS / `CLK_PERIOD_NS)
`define HOLD0_OD_CYC         (`HOLD0_OD_NS / `CLK_PERIOD_NS)
`define CNT_W                14
// CRC polynomials, reflected for LSB-first shifting
`define CRC8_POLY_REFL       8'h8c
`define CRC16_POLY_REFL      16'ha001
`define CRC8_RESET           8'h00
`define CRC16_RESET          16'h0000
`define SCRATCH_END_OFS      5'h1f
`endif

// File: shared/sw_link_pkg.sv
package sw_link_pkg;
   typedef enum logic [1:0] {
      SPEED_STD,
      SPEED_OD,
      SPEED_UNDEF
   } speed_t;
   typedef enum {
      LINK_IDLE,
      LINK_LOW,
      LINK_PDH,
      LINK_PDL,
      LINK_REC
   } link_state_t;
endpackage

// File: verif/sw_bus_master.sv
`timescale 1ns/1ns
module sw_bus_master (
   input  wire logic ref_clk,
   input  wire logic line,
   output logic      m_oe
);
   // Released bus idles high, so a pause between calls never resets the slave
   initial m_oe = 1'b0;

   // One timed slot: pull low, release, sample once, wait out the slot
   // Sampling happens before this cycle's drive change, so it sees a settled line
   task automatic slot(input int low, input int smp, input int total,
                       output logic s, output int lows, output int first);
      lows  = 0;
      first = -1;
      s     = 1'b1;
      for (int i = 0; i < total; i++) begin
         @(posedge ref_clk);
         #1;
         if (i == smp) s = line;
         if (i > low && line === 1'b0) begin
            lows++;
            if (first < 0) first = i - low;
         end
         m_oe = (i < low);
      end
   endtask
endmodule

// File: verif/sw_link_slave_tb.sv
`timescale 1ns/1ns
`include "sw_link_consts.svh"
module sw_link_slave_tb;
   logic        ref_clk       = 1'b0;
   logic        rst_n         = 1'b0;
   logic        od_set        = 1'b0;
   logic        tx_req        = 1'b0;
   logic        tx_bit        = 1'b0;
   logic        crc_clear     = 1'b0;
   logic        crc_feed      = 1'b0;
   logic [4:0]  write_end_ofs = 5'h00;
   logic        line_out;
   logic        line_oe;
   logic        bit_valid_ff;
   logic        bit_data_ff;
   logic        bus_reset_ff;
   logic        overdrive_flag_ff;
   logic        speed_undef_ff;
   logic        ready_ff;
   logic [7:0]  crc8_out_ff;
   logic [15:0] crc16_tx_ff;
   logic        crc16_send_ff;
   logic        m_oe;
   logic        line;
   logic        last_bit;
   logic        oe_q          = 1'b0;
   logic [15:0] exp16;
   logic [7:0]  exp8;
   int          err_count     = 0;
   int          cmp_count     = 0;
   int          bit_cnt       = 0;
   int          rst_cnt       = 0;
   int          oe_rise       = 0;
   // Slot timing in cycles, index 0 standard, 1 overdrive
   int          low1_c[2]     = '{100, 20};
   int          low0_c[2]     = '{1200, 150};
   int          slot_c[2]     = '{1400, 200};
   int          rsmp_c[2]     = '{300, 60};
   int          psmp_c[2]     = '{1400, 160};
   int          rhi_c[2]      = '{3200, 400};
   int          pdh_c[2]      = '{`PDH_STD_CYC, `PDH_OD_CYC};
   int          pdl_c[2]      = '{`PDL_STD_CYC, `PDL_OD_CYC};
   logic [7:0]  wr_bytes[4]   = '{8'h0f, 8'h1e, 8'h00, 8'ha5};

   always #25 ref_clk = ~ref_clk;
   // Open-drain wire with pull-up: low if either side pulls
   assign line = !m_oe && (!line_oe || line_out);

   sw_link_slave DUT (.ref_clk(ref_clk), .rst_n(rst_n), .line_in(line), .line_out(line_out), .line_oe(line_oe),
      .od_set(od_set), .tx_req(tx_req), .tx_bit(tx_bit), .crc_clear(crc_clear), .crc_feed(crc_feed),
      .write_end_ofs(write_end_ofs), .bit_valid_ff(bit_valid_ff), .bit_data_ff(bit_data_ff),
      .bus_reset_ff(bus_reset_ff), .overdrive_flag_ff(overdrive_flag_ff), .speed_undef_ff(speed_undef_ff),
      .ready_ff(ready_ff), .crc8_out_ff(crc8_out_ff), .crc16_tx_ff(crc16_tx_ff), .crc16_send_ff(crc16_send_ff));

   sw_bus_master master (.ref_clk(ref_clk), .line(line), .m_oe(m_oe));

   always @(posedge ref_clk) begin
      if (bit_valid_ff === 1'b1) begin
         bit_cnt++;
         last_bit = bit_data_ff;
      end
      if (bus_reset_ff === 1'b1) rst_cnt++;
      if (line_oe === 1'b1 && oe_q !== 1'b1) oe_rise++;
      oe_q = line_oe;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic do_reset(input int low, input int od);
      int r0, o0, lows, first;
      logic s;
      r0 = rst_cnt;
      o0 = oe_rise;
      master.slot(low, low + psmp_c[od], low + rhi_c[od], s, lows, first);
      check("presence seen", s, 1'b0);
      check("presence delay", first >= pdh_c[od] && first <= pdh_c[od] + 8, 1'b1);
      check("presence width", lows >= pdl_c[od] - 2 && lows <= pdl_c[od] + 2, 1'b1);
      check("reset pulse", rst_cnt - r0, 16'h1);
      check("presence falls", oe_rise - o0, 16'h1);
      check("ready", ready_ff, 1'b1);
   endtask

   task automatic wr_bit(input logic b, input int od);
      int c0, o0, lows, first;
      logic s;
      c0 = bit_cnt;
      o0 = oe_rise;
      master.slot(b ? low1_c[od] : low0_c[od], 0, slot_c[od], s, lows, first);
      check("write count", bit_cnt - c0, 16'h1);
      check("write bit", last_bit, b);
      check("write no drive", oe_rise - o0, 16'h0);
   endtask

   task automatic rd_bit(input logic b, input int od);
      int c0, o0, lows, first;
      logic s;
      c0 = bit_cnt;
      o0 = oe_rise;
      tx_req = 1'b1;
      tx_bit = b;
      master.slot(low1_c[od], rsmp_c[od], slot_c[od], s, lows, first);
      tx_req = 1'b0;
      check("read bit", s, b);
      check("read drive", oe_rise - o0, !b);
      check("read count", bit_cnt - c0, 16'h1);
   endtask

   task automatic t_std;
      do_reset(9700, 0);
      check("std after reset", overdrive_flag_ff, 1'b0);
      wr_bit(1'b1, 0);
      wr_bit(1'b0, 0);
      rd_bit(1'b0, 0);
      rd_bit(1'b1, 0);
      $display("test std_slots done");
   endtask

   // Single-cycle dip never sits in sync stages two and three at once
   task automatic t_glitch;
      int c0, o0, lows, first;
      logic s;
      c0 = bit_cnt;
      o0 = oe_rise;
      master.slot(1, 0, 800, s, lows, first);
      check("glitch bit", bit_cnt - c0, 16'h0);
      check("glitch drive", oe_rise - o0, 16'h0);
      $display("test glitch done");
   endtask

   task automatic t_od;
      logic bv;
      od_set = 1'b1;
      tick(1);
      od_set = 1'b0;
      tick(2);
      check("od set", overdrive_flag_ff, 1'b1);
      do_reset(800, 1);
      check("od kept", overdrive_flag_ff, 1'b1);
      crc_clear = 1'b1;
      tick(1);
      crc_clear = 1'b0;
      tick(2);
      check("crc cleared", crc16_tx_ff, 16'hffff);
      crc_feed = 1'b1;
      exp16 = 16'h0000;
      exp8 = 8'h00;
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 8; j++) begin
            bv = wr_bytes[k][j];
            wr_bit(bv, 1);
            exp16 = (exp16 >> 1) ^ ((exp16[0] ^ bv) ? 16'ha001 : 16'h0000);
            exp8 = (exp8 >> 1) ^ ((exp8[0] ^ bv) ? 8'h8c : 8'h00);
         end
      end
      crc_feed = 1'b0;
      tick(3);
      check("crc16", crc16_tx_ff, ~exp16);
      check("crc8", crc8_out_ff, exp8);
      rd_bit(1'b0, 1);
      rd_bit(1'b1, 1);
      write_end_ofs = 5'h1f;
      tick(3);
      check("crc send end", crc16_send_ff, 1'b1);
      write_end_ofs = 5'h1e;
      tick(3);
      check("crc send short", crc16_send_ff, 1'b0);
      $display("test overdrive done");
   endtask

   task automatic t_speed;
      do_reset(4000, 1);
      check("undef flag", speed_undef_ff, 1'b1);
      do_reset(9700, 0);
      check("od cleared", overdrive_flag_ff, 1'b0);
      check("undef cleared", speed_undef_ff, 1'b0);
      $display("test speed done");
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge ref_clk);
      err_count++;
      end_of_test();
   end

   initial begin
      tick(4);
      check("reset oe", line_oe, 1'b0);
      check("reset crc", crc16_tx_ff, 16'hffff);
      rst_n = 1'b1;
      tick(2);
      t_std();
      t_glitch();
      t_od();
      t_speed();
      end_of_test();
   end
endmodule
